// File: bench/dbg_ctl_assertions.sv
// Port checks for the debugger control and status registers
`timescale 1ns/1ps
module dbg_ctl_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire dbg_ctl_pkg::byte_t cmd_byte,
    input wire logic resp_valid,
    input wire dbg_ctl_pkg::byte_t resp_byte,
    input wire logic brk_decoded,
    input wire logic readout_lock_option_n,
    input wire logic cpu_fetch_stop,
    input wire logic cpu_brk_nop,
    input wire logic cpu_brk_spin,
    input wire logic device_reset_req
);
    import dbg_ctl_pkg::*;
    logic arm_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Mirrors the decoder so a data byte is never mistaken for a command
    always_ff @(posedge clk) begin
        arm_r <= rst_n && (cmd_valid ? !arm_r && cmd_byte == 8'h04 : arm_r);
    end
    sequence s_data; arm_r && cmd_valid; endsequence
    a_brk_halt: assert property (brk_decoded && !cpu_brk_nop && !cpu_brk_spin |=> cpu_fetch_stop)
        else $error("breakpoint did not halt");
    a_nop_brk: assert property (brk_decoded && cpu_brk_nop && !cpu_fetch_stop && !cmd_valid |=> !cpu_fetch_stop)
        else $error("disabled breakpoint halted");
    a_spin_brk: assert property (brk_decoded && cpu_brk_spin && !cpu_fetch_stop && !cmd_valid |=> !cpu_fetch_stop)
        else $error("spin breakpoint halted");
    a_halt_write: assert property (s_data ##0 cmd_byte[7] |=> cpu_fetch_stop)
        else $error("halt write ignored");
    a_halt_clear: assert property (readout_lock_option_n [*3] ##0 s_data ##0 !cmd_byte[7] && !brk_decoded |=> !cpu_fetch_stop)
        else $error("halt clear ignored");
    a_lock_hold: assert property (!readout_lock_option_n [*3] ##0 cpu_fetch_stop ##0 s_data |=> cpu_fetch_stop)
        else $error("halt cleared under lock");
    a_self_rst: assert property (s_data ##0 cmd_byte[0] |=> device_reset_req)
        else $error("self reset not started");
    a_rst_len: assert property ($rose(device_reset_req) |-> ##15 device_reset_req ##1 !device_reset_req)
        else $error("self reset length wrong");
    a_stat_resp: assert property (!arm_r && cmd_valid && cmd_byte == 8'h02 && !brk_decoded |=> resp_valid && resp_byte[4:0] == 5'h00)
        else $error("status answer wrong");
endmodule
bind debugger_control_status_regs dbg_ctl_checker u_dbg_ctl_checker (.clk(clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .resp_valid(resp_valid), .resp_byte(resp_byte),
    .brk_decoded(brk_decoded), .readout_lock_option_n(readout_lock_option_n),
    .cpu_fetch_stop(cpu_fetch_stop), .cpu_brk_nop(cpu_brk_nop), .cpu_brk_spin(cpu_brk_spin),
    .device_reset_req(device_reset_req));

// File: bench/dbg_host.sv
// Debug host model driving the serial command byte stream
`timescale 1ns/1ps
module dbg_host (
    input wire logic clk,
    input wire logic resp_valid,
    input wire dbg_ctl_pkg::byte_t resp_byte,
    output logic cmd_valid = 0,
    output dbg_ctl_pkg::byte_t cmd_byte = 8'h00
);
    import dbg_ctl_pkg::*;
    // Idle byte is inverted so a stale value never reads as a command
    task automatic send(input byte_t b);
        @(posedge clk);
        #1 cmd_valid = 1;
        cmd_byte = b;
        @(posedge clk);
        #1 cmd_valid = 0;
        cmd_byte = ~b;
    endtask
    task automatic wr(input byte_t d);
        send(8'h04);
        send(d & 8'hF1);
    endtask
    task automatic rd(input byte_t c, output byte_t b);
        send(c);
        b = resp_valid ? resp_byte : 8'hxx;
    endtask
endmodule

// File: bench/test_debugger_control_status_regs.sv
// Self-checking bench for the debugger control and status registers
`timescale 1ns/1ps
module test_debugger_control_status_regs;
    import dbg_ctl_pkg::*;
    logic clk = 0, rst_n = 0, breakpoint_opcode, lp, lock_n, cv, rv, fetch, nop, spin, rreq;
    byte_t cb, rb, b;
    int n_fail = 0, num_checks = 0;
    wire logic [7:0] fl = {4'h0, fetch, nop, spin, rreq};
    always #20 clk = ~clk;
    debugger_control_status_regs u_debugger_control_status_regs (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cv), .cmd_byte(cb), .resp_valid(rv), .resp_byte(rb), .brk_decoded(breakpoint_opcode),
        .cpu_lowpower_halt(lp), .readout_lock_option_n(lock_n), .cpu_fetch_stop(fetch),
        .cpu_brk_nop(nop), .cpu_brk_spin(spin), .device_reset_req(rreq));
    dbg_host u_dbg_host (.clk(clk), .resp_valid(rv), .resp_byte(rb), .cmd_valid(cv), .cmd_byte(cb));
    task automatic chk(input string n, input byte_t e, input byte_t g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bp;
        @(posedge clk);
        #1 breakpoint_opcode = 1;
        @(posedge clk);
        #1 breakpoint_opcode = 0;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #50000 n_fail++;
        stop_test;
    end
    initial begin
        breakpoint_opcode = 0;
        lp = 0;
        lock_n = 1;
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        u_dbg_host.rd(8'h05, b); chk("ctl", 8'h00, b);
        bp; chk("flags", 8'h04, fl);
        u_dbg_host.wr(8'h60); bp; chk("ack", 8'hFF, rv ? rb : 8'h00);
        chk("flags", 8'h08, fl);
        u_dbg_host.rd(8'h02, b); chk("stat", 8'h80, b);
        u_dbg_host.wr(8'h40); chk("flags", 8'h00, fl);
        u_dbg_host.rd(8'h02, b); chk("stat", 8'h00, b);
        $display("breakpoint test done");
        u_dbg_host.wr(8'h50); bp; chk("flags", 8'h02, fl);
        u_dbg_host.rd(8'h02, b); chk("stat", 8'h80, b);
        u_dbg_host.wr(8'h81); chk("flags", 8'h0D, fl);
        repeat (16) @(posedge clk);
        #1 chk("flags", 8'h0C, fl);
        u_dbg_host.rd(8'h05, b); chk("ctl", 8'h80, b);
        lp = 1;
        lock_n = 0;
        repeat (3) @(posedge clk);
        u_dbg_host.wr(8'h40); chk("flags", 8'h08, fl);
        u_dbg_host.rd(8'h02, b); chk("stat", 8'hE0, b);
        $display("self reset and lock test done");
        lock_n = 1;
        lp = 0;
        rst_n = 0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1;
        u_dbg_host.wr(8'h41); chk("flags", 8'h01, fl);
        u_dbg_host.rd(8'h02, b); chk("stat", 8'h00, b);
        $display("reset and go test done");
        stop_test;
    end
endmodule

// File: src/dbg_ctl_defines.svh
// Constants for the debugger control and status register block
`ifndef DBG_CTL_DEFINES_SVH
`define DBG_CTL_DEFINES_SVH

`define CTL_HALT_BIT 7
`define CTL_BRK_EN_BIT 6
`define CTL_ACK_EN_BIT 5
`define CTL_SPIN_BIT 4
`define CTL_RSVD_HI 3
`define CTL_RSVD_LO 1
`define CTL_SELF_RST_BIT 0
`define CTL_RESET_VAL 8'h00
`define CTL_WRITE_MASK 8'hF1
`define STAT_STALL_BIT 7
`define STAT_LOWPWR_BIT 6
`define STAT_LOCK_BIT 5
`define CMD_RD_STATUS 8'h02
`define CMD_WR_CONTROL 8'h04
`define CMD_RD_CONTROL 8'h05
`define ACK_BYTE 8'hFF
`define BRK_OPCODE 8'h00
`define SELF_RST_CYCLES 8'h10

`endif

// File: src/dbg_ctl_pkg.sv
// Types for the debugger control and status register block
package dbg_ctl_pkg;
    typedef enum logic [1:0] {
        CMD_IDLE = 2'b00,
        CMD_DATA = 2'b01
    } cmd_state_e;
    typedef logic [7:0] byte_t;
endpackage

// File: src/debugger_control_status_regs.sv
// Debugger control and status registers behind the serial command stream
`timescale 1ns/1ps
`include "dbg_ctl_defines.svh"

// What this block does
// RQ1: 81h resets and halts; 41h resets, runs; 40h resumes
// RQ2: Halt flag set stops CPU instruction fetch
// RQ3: Halt flag cleared resumes normal execution
// RQ4: Enabled breakpoint without spin sets halt flag
// RQ5: Readout lock ignores halt clear; reset only
// RQ6: Breakpoint disabled by default acts as no-op
// RQ7: Acknowledge enable sends FFh on each breakpoint
// RQ8: Spin makes CPU loop on breakpoint instruction
// RQ9: Host writes zero to reserved control bits
// RQ10: Self-reset resets device, sparing debugger state
// RQ11: Self-reset bit clears when sequence completes
// RQ12: Stalled status: halted or breakpoint since write
// RQ13: Status bit six shows low-power halt mode
// RQ14: Status bit five shows readout lock active
// RQ15: Status low bits reserved zero, read-only
// RQ16: Command 04h writes control, 05h reads it
// RQ17: Command 02h returns one status byte
// RQ18: Control register resets to zero
module debugger_control_status_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire dbg_ctl_pkg::byte_t cmd_byte,
    output logic resp_valid,
    output dbg_ctl_pkg::byte_t resp_byte,
    input wire logic brk_decoded,
    input wire logic cpu_lowpower_halt,
    input wire logic readout_lock_option_n,
    output logic cpu_fetch_stop,
    output logic cpu_brk_nop,
    output logic cpu_brk_spin,
    output logic device_reset_req
);
    import dbg_ctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: option and halt state come from outside this clock
    logic lock_s1_r;
    logic lock_s2_r;
    logic lp_s1_r;
    logic lp_s2_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lock_s1_r <= 1'b1;
            lock_s2_r <= 1'b1;
            lp_s1_r <= 1'b0;
            lp_s2_r <= 1'b0;
        end else begin
            lock_s1_r <= readout_lock_option_n;
            lock_s2_r <= lock_s1_r;
            lp_s1_r <= cpu_lowpower_halt;
            lp_s2_r <= lp_s1_r;
        end
    end

    logic lock_active;
    assign lock_active = ~lock_s2_r; // [RQ14]

    ////////////////////////////////////////////////////////////////////////
    // Command decoder
    cmd_state_e state_r;
    logic ctl_wr;
    assign ctl_wr = cmd_valid && (state_r == CMD_DATA);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= CMD_IDLE;
        end else if (cmd_valid) begin
            case (state_r)
                CMD_IDLE: begin
                    if (cmd_byte == `CMD_WR_CONTROL) begin
                        state_r <= CMD_DATA; // [RQ16]
                    end
                end
                CMD_DATA: begin
                    state_r <= CMD_IDLE;
                end
                default: begin
                    state_r <= CMD_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register and self-reset sequencer
    byte_t ctl_r;
    byte_t ctl_nxt;
    logic [7:0] rst_cnt_r;
    logic rst_done;
    logic brk_event;
    logic brk_enabled;

    assign brk_enabled = ctl_r[`CTL_BRK_EN_BIT];
    assign brk_event = brk_decoded && brk_enabled; // [RQ6]
    assign rst_done = ctl_r[`CTL_SELF_RST_BIT] && (rst_cnt_r == 8'h01);

    always_comb begin
        ctl_nxt = ctl_r;
        if (ctl_wr) begin
            // Reserved bits are stored as zero whatever the host sends
            ctl_nxt = cmd_byte & `CTL_WRITE_MASK; // [RQ1] [RQ9]
            if (lock_active && ctl_r[`CTL_HALT_BIT]) begin
                ctl_nxt[`CTL_HALT_BIT] = 1'b1; // [RQ5]
            end
        end
        if (brk_event && !ctl_r[`CTL_SPIN_BIT]) begin
            ctl_nxt[`CTL_HALT_BIT] = 1'b1; // [RQ4]
        end
        if (rst_done && !ctl_wr) begin
            ctl_nxt[`CTL_SELF_RST_BIT] = 1'b0; // [RQ11]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_r <= `CTL_RESET_VAL; // [RQ18]
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // Counter reloads on each self-reset write, so a repeat restarts it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_cnt_r <= 8'h00;
        end else if (ctl_wr && cmd_byte[`CTL_SELF_RST_BIT]) begin
            rst_cnt_r <= `SELF_RST_CYCLES; // [RQ10]
        end else if (rst_cnt_r != 8'h00) begin
            rst_cnt_r <= rst_cnt_r - 8'h01;
        end
    end

    // Only the rest of the device sees this reset; the debugger keeps state
    assign device_reset_req = ctl_r[`CTL_SELF_RST_BIT]; // [RQ10]
    assign cpu_fetch_stop = ctl_r[`CTL_HALT_BIT]; // [RQ2] [RQ3]
    assign cpu_brk_nop = !brk_enabled; // [RQ6]
    assign cpu_brk_spin = brk_enabled && ctl_r[`CTL_SPIN_BIT]; // [RQ8]

    ////////////////////////////////////////////////////////////////////////
    // Breakpoint seen since last control write
    logic brk_seen_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            brk_seen_r <= 1'b0;
        end else if (brk_event) begin
            brk_seen_r <= 1'b1; // [RQ12]
        end else if (ctl_wr) begin
            brk_seen_r <= 1'b0;
        end
    end

    byte_t status;
    always_comb begin
        status = 8'h00; // [RQ15]
        status[`STAT_STALL_BIT] = ctl_r[`CTL_HALT_BIT] | brk_seen_r; // [RQ12]
        status[`STAT_LOWPWR_BIT] = lp_s2_r; // [RQ13]
        status[`STAT_LOCK_BIT] = lock_active; // [RQ14]
    end

    ////////////////////////////////////////////////////////////////////////
    // Response path; acknowledge byte takes priority over a read answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resp_valid <= 1'b0;
            resp_byte <= 8'h00;
        end else begin
            resp_valid <= 1'b0;
            if (brk_event && ctl_r[`CTL_ACK_EN_BIT]) begin
                resp_valid <= 1'b1;
                resp_byte <= `ACK_BYTE; // [RQ7]
            end else if (cmd_valid && state_r == CMD_IDLE) begin
                if (cmd_byte == `CMD_RD_STATUS) begin
                    resp_valid <= 1'b1;
                    resp_byte <= status; // [RQ17]
                end else if (cmd_byte == `CMD_RD_CONTROL) begin
                    resp_valid <= 1'b1;
                    resp_byte <= ctl_r; // [RQ16]
                end
            end
        end
    end
endmodule
